// ==== shared/sbd_pkg.sv ====
// Constants and types for the sequencer branch decode block
// Assumes a 10 MHz APB clock and one command line per accepted step
package sbd_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int         PC_W      = 10;
  localparam int         STK_DEPTH = 4;
  localparam int         STK_AW    = 2;
  localparam int         SP_W      = 3;
  localparam int         ERR_W     = 3;
  localparam logic [9:0] PC_RST    = 10'h000;

  // ----------------------------------------------------------------
  // ALU/branch control opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_OR       = 4'h0;
  localparam logic [3:0] OP_AND      = 4'h1;
  localparam logic [3:0] OP_XOR      = 4'h2;
  localparam logic [3:0] OP_ADD      = 4'h3;
  localparam logic [3:0] OP_ADC      = 4'h4;
  localparam logic [3:0] OP_ROL      = 4'h5;
  localparam logic [3:0] OP_RSVD6    = 4'h6;
  localparam logic [3:0] OP_RSVD7    = 4'h7;
  localparam logic [3:0] OP_ORI_JMP  = 4'h8;
  localparam logic [3:0] OP_ORI_JCS  = 4'h9;
  localparam logic [3:0] OP_ORI_JNC  = 4'ha;
  localparam logic [3:0] OP_ORI_CALL = 4'hb;
  localparam logic [3:0] OP_XOR_JNZ  = 4'hc;
  localparam logic [3:0] OP_AND_JNZ  = 4'hd;
  localparam logic [3:0] OP_XOR_JZR  = 4'he;
  localparam logic [3:0] OP_AND_JZR  = 4'hf;

  localparam logic [1:0] FMT_NONE = 2'h0;
  localparam logic [1:0] FMT_1    = 2'h1;
  localparam logic [1:0] FMT_2    = 2'h2;
  localparam logic [1:0] FMT_3    = 2'h3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERR    = 8'h08;
  localparam int         CTRL_RUN_BIT  = 0;
  localparam int         CTRL_LOAD_BIT = 1;
  localparam int         CTRL_PC_LSB   = 16;
  localparam logic       RUN_RST       = 1'b0;
  localparam int         ST_CARRY_BIT  = 12;
  localparam int         ST_ZERO_BIT   = 13;
  localparam int         ST_DEPTH_LSB  = 16;
  localparam int         ERR_OVF_BIT   = 0;
  localparam int         ERR_UNF_BIT   = 1;
  localparam int         ERR_RSVD_BIT  = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ALU_NONE, ALU_OR, ALU_AND, ALU_XOR, ALU_ADD, ALU_ADC, ALU_ORI, ALU_ROL
  } sbd_alu_t;

  typedef enum logic [2:0] {
    BR_NO_BRANCH, BR_JUMP, BR_JUMP_IF_ZERO_RESULT, BR_JUMP_IF_NONZERO,
    BR_JUMP_IF_CARRY_SET, BR_JUMP_IF_CARRY_CLEAR, BR_CALL, BR_RETURN
  } sbd_branch_t;

  typedef struct packed {
    logic [3:0]      opcode;
    logic            ret;
    logic [PC_W-1:0] next_addr;
  } sbd_cmd_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } sbd_res_t;

  typedef struct packed {
    sbd_alu_t    fn;
    sbd_branch_t br;
    logic [1:0]  fmt;
    logic        has_dest;
    logic        rsvd;
  } sbd_dec_t;

endpackage

// ==== src/sbd_decode.sv ====
// Opcode and return-field decoder of the sequencer
// Assumes the command line is stable while it is presented
`timescale 1ns/1ps
module sbd_decode (
  // Command line in
  input  sbd_pkg::sbd_cmd_t cmd,
  // Decoded fields out
  output sbd_pkg::sbd_dec_t dec
);
  import sbd_pkg::*;

  // ----------------------------------------------------------------
  // Opcode table
  // ----------------------------------------------------------------
  function automatic sbd_dec_t sbd_decode_op(input logic [3:0] op, input logic ret);
    sbd_dec_t d;
    d = '{fn: ALU_NONE, br: BR_NO_BRANCH, fmt: FMT_NONE, has_dest: 1'b0, rsvd: 1'b0};
    unique case (op)
      OP_OR:       begin d.fn = ALU_OR;  d.fmt = FMT_1; end
      OP_AND:      begin d.fn = ALU_AND; d.fmt = FMT_1; end
      OP_XOR:      begin d.fn = ALU_XOR; d.fmt = FMT_1; end
      OP_ADD:      begin d.fn = ALU_ADD; d.fmt = FMT_1; end
      OP_ADC:      begin d.fn = ALU_ADC; d.fmt = FMT_1; end
      OP_ROL:      begin d.fn = ALU_ROL; d.fmt = FMT_2; end
      OP_RSVD6,
      OP_RSVD7:    d.rsvd = 1'b1;
      OP_ORI_JMP:  begin d.fn = ALU_ORI; d.br = BR_JUMP;                d.fmt = FMT_3; end
      OP_ORI_JCS:  begin d.fn = ALU_ORI; d.br = BR_JUMP_IF_CARRY_SET;   d.fmt = FMT_3; end
      OP_ORI_JNC:  begin d.fn = ALU_ORI; d.br = BR_JUMP_IF_CARRY_CLEAR; d.fmt = FMT_3; end
      OP_ORI_CALL: begin d.fn = ALU_ORI; d.br = BR_CALL;                d.fmt = FMT_3; end
      OP_XOR_JNZ:  begin d.fn = ALU_XOR; d.br = BR_JUMP_IF_NONZERO;     d.fmt = FMT_3; end
      OP_AND_JNZ:  begin d.fn = ALU_AND; d.br = BR_JUMP_IF_NONZERO;     d.fmt = FMT_3; end
      OP_XOR_JZR:  begin d.fn = ALU_XOR; d.br = BR_JUMP_IF_ZERO_RESULT; d.fmt = FMT_3; end
      OP_AND_JZR:  begin d.fn = ALU_AND; d.br = BR_JUMP_IF_ZERO_RESULT; d.fmt = FMT_3; end
    endcase
    // Target address shares bits with the destination
    d.has_dest = (d.fmt == FMT_1) || (d.fmt == FMT_2);
    // Return comes from its own field, only beside no-branch opcodes
    if (ret && d.has_dest) begin
      d.br = BR_RETURN;
    end
    return d;
  endfunction

  assign dec = sbd_decode_op(cmd.opcode, cmd.ret);

endmodule

// ==== src/sbd_stack.sv ====
// Return address stack with registered top-of-stack output
// Assumes push and pop are never asserted together
`timescale 1ns/1ps
module sbd_stack (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Stack control
  input  wire logic                     push,
  input  wire logic                     pop,
  input  wire logic [sbd_pkg::PC_W-1:0] wdata,
  // Stack state
  output logic      [sbd_pkg::PC_W-1:0] top_q,
  output logic      [sbd_pkg::SP_W-1:0] depth,
  output logic                          full,
  output logic                          empty
);
  import sbd_pkg::*;

  logic [PC_W-1:0]   mem [STK_DEPTH];
  logic [SP_W-1:0]   sp_q;
  logic [SP_W-1:0]   sp_d;
  logic [STK_AW-1:0] below_idx;
  logic              do_push;
  logic              do_pop;

  assign full      = (sp_q == SP_W'(STK_DEPTH));
  assign empty     = (sp_q == '0);
  assign depth     = sp_q;
  assign do_push   = push && !full;
  assign do_pop    = pop && !empty;
  assign below_idx = STK_AW'(sp_q - 3'h2);
  assign sp_d      = do_push ? SP_W'(sp_q + 3'h1) : do_pop ? SP_W'(sp_q - 3'h1) : sp_q;

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[STK_AW'(sp_q)] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q  <= '0;
      top_q <= PC_RST;
    end else begin
      sp_q <= sp_d;
      if (do_push) begin
        top_q <= wdata;
      end else if (do_pop) begin
        top_q <= (sp_q >= 3'h2) ? mem[below_idx] : PC_RST;
      end
    end
  end

endmodule

// ==== src/sbd_seq_branch.sv ====
// Sequencer branch logic: program counter, flags, return stack, APB regs
// Assumes the ALU beside it reports carry and zero for the current line
//
// What this block does
// - JNC branches on clear carry, else steps
// - Carry changes only on lines with destination
// - No opcode mixes carry branch with carry update
// - Call pushes address plus one, then jumps
// - Return loads top of stack and pops
// - Return chosen by its own field
// - No branch advances to next line
// - Target and destination share the same bits
// - Branches besides return live in opcode
// - Fourteen valid opcodes; six, seven reserved
// - Opcodes 0-4 are plain ALU, format 1
// - Opcodes 12-15 test zero result, format 3
// - Opcodes 8-11 are immediate OR with jumps
// - Format from opcode; 5 is rotate, format 2
// - Zero tests use current line's result
// - Jump-if-carry branches when last carry set
// - Unconditional jump loads the target address
`timescale 1ns/1ps
module sbd_seq_branch (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic [7:0]               paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Command line from control store
  input  wire logic                     cmd_valid,
  output logic                          cmd_ready,
  input  sbd_pkg::sbd_cmd_t             cmd,
  input  sbd_pkg::sbd_res_t             res,
  // Sequencer state out
  output logic      [sbd_pkg::PC_W-1:0] pc,
  output sbd_pkg::sbd_alu_t             alu_fn,
  output sbd_pkg::sbd_branch_t          branch,
  output logic      [1:0]               line_fmt,
  output logic                          carry,
  output logic                          zero
);
  import sbd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sbd_dec_t          dec;
  logic [PC_W-1:0]   pc_q;
  logic [PC_W-1:0]   pc_d;
  logic [PC_W-1:0]   pc_inc;
  logic [PC_W-1:0]   tgt_w;
  logic [PC_W-1:0]   stk_top;
  logic [SP_W-1:0]   stk_depth;
  logic              stk_full;
  logic              stk_empty;
  logic              carry_q;
  logic              carry_d;
  logic              zero_q;
  logic              zero_d;
  logic              res_zero_w;
  logic              run_q;
  logic [PC_W-1:0]   ctrl_pc_q;
  logic [ERR_W-1:0]  err_q;
  logic [ERR_W-1:0]  err_d;
  logic [ERR_W-1:0]  err_set;
  logic [ERR_W-1:0]  err_clr;
  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;
  logic [31:0]       ctrl_word;
  logic [31:0]       status_word;
  logic              go;
  logic              take_tgt;
  logic              is_call;
  logic              is_ret;
  logic              load_w;
  logic              acc;
  logic              wr;
  logic              hit_ctrl;
  logic              hit_status;
  logic              hit_err;
  logic              hit;

  // ----------------------------------------------------------------
  // Decoder and return stack
  // ----------------------------------------------------------------
  sbd_decode u_decode (
    .cmd (cmd),
    .dec (dec)
  );

  sbd_stack u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (go && is_call),
    .pop     (go && is_ret),
    .wdata   (pc_inc),
    .top_q   (stk_top),
    .depth   (stk_depth),
    .full    (stk_full),
    .empty   (stk_empty)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign acc        = psel && penable;
  assign wr         = acc && pwrite;
  assign hit_ctrl   = (paddr == ADDR_CTRL);
  assign hit_status = (paddr == ADDR_STATUS);
  assign hit_err    = (paddr == ADDR_ERR);
  assign hit        = hit_ctrl || hit_status || hit_err;
  assign pready     = 1'b1;
  assign pslverr    = acc && !hit;
  assign prdata     = prdata_q;
  assign load_w     = wr && hit_ctrl && pwdata[CTRL_LOAD_BIT];
  assign err_clr    = (wr && hit_err) ? pwdata[ERR_W-1:0] : '0;

  assign ctrl_word   = (32'(ctrl_pc_q) << CTRL_PC_LSB) | 32'(run_q);
  assign status_word = 32'(pc_q)
                     | (32'(carry_q) << ST_CARRY_BIT)
                     | (32'(zero_q) << ST_ZERO_BIT)
                     | (32'(stk_depth) << ST_DEPTH_LSB);
  assign prdata_d    = hit_ctrl   ? ctrl_word
                     : hit_status ? status_word
                     : hit_err    ? 32'(err_q)
                     : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Branch selection
  // ----------------------------------------------------------------
  // Software load of the counter blocks a step in the same cycle
  assign cmd_ready  = run_q && !load_w;
  assign go         = cmd_valid && cmd_ready;
  assign tgt_w      = cmd.next_addr;
  assign res_zero_w = res.zero;
  assign pc_inc     = PC_W'(pc_q + 10'h001);
  assign is_call    = (dec.br == BR_CALL);
  assign is_ret     = (dec.br == BR_RETURN);

  assign take_tgt = (dec.br == BR_JUMP)
                 || is_call
                 || ((dec.br == BR_JUMP_IF_ZERO_RESULT) && res.zero)
                 || ((dec.br == BR_JUMP_IF_NONZERO) && !res.zero)
                 || ((dec.br == BR_JUMP_IF_CARRY_SET) && carry_q)
                 || ((dec.br == BR_JUMP_IF_CARRY_CLEAR) && !carry_q);

  assign pc_d = load_w   ? ctrl_pc_q
              : !go      ? pc_q
              : is_ret   ? stk_top
              : take_tgt ? tgt_w
              : pc_inc;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  assign carry_d = (go && dec.has_dest) ? res.carry : carry_q;
  assign zero_d  = (go && !dec.rsvd) ? res.zero : zero_q;

  assign err_set[ERR_OVF_BIT]  = go && is_call && stk_full;
  assign err_set[ERR_UNF_BIT]  = go && is_ret && stk_empty;
  assign err_set[ERR_RSVD_BIT] = go && dec.rsvd;
  // New events win over a clear in the same cycle
  assign err_d = (err_q & ~err_clr) | err_set;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q    <= PC_RST;
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
      err_q   <= '0;
    end else begin
      pc_q    <= pc_d;
      carry_q <= carry_d;
      zero_q  <= zero_d;
      err_q   <= err_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q     <= RUN_RST;
      ctrl_pc_q <= PC_RST;
      prdata_q  <= 32'h0000_0000;
    end else begin
      if (wr && hit_ctrl) begin
        run_q     <= pwdata[CTRL_RUN_BIT];
        ctrl_pc_q <= pwdata[CTRL_PC_LSB +: PC_W];
      end
      if (psel && !penable && !pwrite) begin
        prdata_q <= prdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pc       = pc_q;
  assign alu_fn   = dec.fn;
  assign branch   = dec.br;
  assign line_fmt = dec.fmt;
  assign carry    = carry_q;
  assign zero     = zero_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_jnc_taken: assert property (
    go && (dec.br == BR_JUMP_IF_CARRY_CLEAR) && !carry_q |=> pc_q == $past(tgt_w)
  ) else $error("jnc with carry clear did not branch");

  a_jnc_fall: assert property (
    go && (dec.br == BR_JUMP_IF_CARRY_CLEAR) && carry_q |=> pc_q == $past(pc_inc)
  ) else $error("jnc with carry set did not step");

  a_carry_hold: assert property (
    !(go && dec.has_dest) |=> $stable(carry_q)
  ) else $error("carry changed without destination line");

  a_carry_nomix: assert property (
    (dec.br == BR_JUMP_IF_CARRY_SET) || (dec.br == BR_JUMP_IF_CARRY_CLEAR) |-> !dec.has_dest
  ) else $error("carry branch decoded with carry update");

  a_call_push: assert property (
    go && is_call && !stk_full |=> (stk_top == $past(pc_inc)) && (pc_q == $past(tgt_w))
  ) else $error("call did not push return and jump");

  a_ret_pop: assert property (
    go && is_ret && !stk_empty |=> (pc_q == $past(stk_top))
      && (stk_depth == SP_W'($past(stk_depth) - 3'h1))
  ) else $error("return did not load and pop");

  a_ret_field: assert property (
    cmd.ret && (cmd.opcode <= OP_ROL) |-> dec.br == BR_RETURN
  ) else $error("return field ignored on no-branch line");

  a_plain_step: assert property (
    go && (dec.br == BR_NO_BRANCH) |=> pc_q == $past(pc_inc)
  ) else $error("no-branch line did not step");

  a_rol_fmt: assert property (
    cmd.opcode == OP_ROL |-> (dec.fmt == FMT_2) && (dec.fn == ALU_ROL)
  ) else $error("rotate opcode decoded wrongly");

  a_zero_result: assert property (
    go && (dec.br == BR_JUMP_IF_ZERO_RESULT) |=>
      pc_q == ($past(res_zero_w) ? $past(tgt_w) : $past(pc_inc))
  ) else $error("zero branch took wrong path");

  a_jcs_taken: assert property (
    go && (dec.br == BR_JUMP_IF_CARRY_SET) && carry_q |=> pc_q == $past(tgt_w)
  ) else $error("carry-set jump did not branch");

  a_jcs_fall: assert property (
    go && (dec.br == BR_JUMP_IF_CARRY_SET) && !carry_q |=> pc_q == $past(pc_inc)
  ) else $error("carry-set jump with carry clear did not step");

  a_nonzero_result: assert property (
    go && (dec.br == BR_JUMP_IF_NONZERO) |=>
      pc_q == ($past(res_zero_w) ? $past(pc_inc) : $past(tgt_w))
  ) else $error("nonzero branch took wrong path");

  a_jmp_load: assert property (
    go && (dec.br == BR_JUMP) |=> pc_q == $past(tgt_w)
  ) else $error("jump did not load target");

  a_rsvd_nop: assert property (
    go && dec.rsvd |=> (pc_q == $past(pc_inc)) && $stable(carry_q) && $stable(zero_q)
      && $stable(stk_depth) && err_q[ERR_RSVD_BIT]
  ) else $error("reserved opcode was not a harmless step");

  a_plain_decode: assert property (
    (cmd.opcode <= OP_ADC) |-> (dec.fmt == FMT_1)
      && ((dec.br == BR_NO_BRANCH) || (dec.br == BR_RETURN))
  ) else $error("plain ALU opcode decoded wrongly");

  a_branch_decode: assert property (
    cmd.opcode[3] |-> (dec.fmt == FMT_3) && !dec.has_dest && (dec.br != BR_RETURN)
  ) else $error("branch opcode decoded wrongly");

  a_rsvd_decode: assert property (
    (cmd.opcode == OP_RSVD6) || (cmd.opcode == OP_RSVD7) |-> dec.rsvd && (dec.fmt == FMT_NONE)
  ) else $error("reserved opcode not flagged");

  c_call_ret: cover property (
    go && is_call ##[1:20] go && is_ret
  );

  c_jnc_taken: cover property (
    go && (dec.br == BR_JUMP_IF_CARRY_CLEAR) && !carry_q
  );

  c_rsvd_seen: cover property (
    go && dec.rsvd
  );

endmodule

// ==== sim/sbd_testbench.sv ====
// Self-checking bench for the sequencer branch logic, with a queue model
// Assumes zero-wait APB and a decoder that follows the command line at once
`timescale 1ns/1ps
module testbench;
  import sbd_pkg::*;

  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  logic              pclk      = 1'b0;
  logic              presetn   = 1'b0;
  logic [7:0]        paddr     = 8'h00;
  logic              psel      = 1'b0;
  logic              penable   = 1'b0;
  logic              pwrite    = 1'b0;
  logic [31:0]       pwdata    = 32'h0000_0000;
  logic              cmd_valid = 1'b0;
  sbd_cmd_t          cmd       = '0;
  sbd_res_t          res       = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              cmd_ready;
  logic [PC_W-1:0]   pc;
  sbd_alu_t          alu_fn;
  sbd_branch_t       branch;
  logic [1:0]        line_fmt;
  logic              carry;
  logic              zero;
  logic [31:0]       rd;
  logic              se;
  int                err_count = 0;
  int                cmp_count = 0;
  int                mpc = 0;
  int                mc = 0;
  int                mz = 0;
  int                mrun = 0;
  int                merr = 0;
  int                stk[$];
  sbd_alu_t          fn_e[16]  = '{ALU_OR, ALU_AND, ALU_XOR, ALU_ADD, ALU_ADC, ALU_ROL,
                                   ALU_NONE, ALU_NONE, ALU_ORI, ALU_ORI, ALU_ORI, ALU_ORI,
                                   ALU_XOR, ALU_AND, ALU_XOR, ALU_AND};
  sbd_branch_t       br_e[16]  = '{BR_NO_BRANCH, BR_NO_BRANCH, BR_NO_BRANCH, BR_NO_BRANCH,
                                   BR_NO_BRANCH, BR_NO_BRANCH, BR_NO_BRANCH, BR_NO_BRANCH,
                                   BR_JUMP, BR_JUMP_IF_CARRY_SET,
                                   BR_JUMP_IF_CARRY_CLEAR, BR_CALL,
                                   BR_JUMP_IF_NONZERO, BR_JUMP_IF_NONZERO,
                                   BR_JUMP_IF_ZERO_RESULT, BR_JUMP_IF_ZERO_RESULT};
  logic [1:0]        fmt_e[16] = '{FMT_1, FMT_1, FMT_1, FMT_1, FMT_1, FMT_2, FMT_NONE, FMT_NONE,
                                   FMT_3, FMT_3, FMT_3, FMT_3, FMT_3, FMT_3, FMT_3, FMT_3};

  always #50 pclk = ~pclk;

  sbd_seq_branch u_sbd_seq_branch (
    .pclk      (pclk),
    .presetn   (presetn),
    .paddr     (paddr),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd       (cmd),
    .res       (res),
    .pc        (pc),
    .alu_fn    (alu_fn),
    .branch    (branch),
    .line_fmt  (line_fmt),
    .carry     (carry),
    .zero      (zero)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task end_sim;
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer, entered and left at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cmd_valid <= 1'b0;
    psel      <= 1'b1;
    penable   <= 1'b0;
    pwrite    <= w;
    paddr     <= a;
    pwdata    <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so a following setup never re-drives psel in this time step
    @(posedge pclk);
  endtask

  task status;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", (stk.size() << ST_DEPTH_LSB) | (mz << ST_ZERO_BIT) |
        (mc << ST_CARRY_BIT) | mpc, rd);
  endtask

  // Presents one line, checks state and decode, model steps at the edge
  task step(input int op, input int r, input int na, input int rc, input int rz,
            input int v);
    int npc;
    cmd       <= {op[3:0], r[0], na[9:0]};
    res       <= {rc[0], rz[0]};
    cmd_valid <= v[0];
    #50;
    chk("pc", mpc, pc);
    chk("carry", mc, carry);
    chk("zero", mz, zero);
    chk("cmd_ready", mrun, cmd_ready);
    chk("alu_fn", fn_e[op], alu_fn);
    chk("branch", (op < 6 && r != 0) ? BR_RETURN : br_e[op], branch);
    chk("line_fmt", fmt_e[op], line_fmt);
    npc = (mpc + 1) & 'h3ff;
    if (v != 0 && mrun != 0) begin
      if (op < 6) begin
        mc = rc;
        mz = rz;
        if (r != 0 && stk.size() == 0) begin
          npc = 0;
          merr |= 2;
        end else if (r != 0) npc = stk.pop_back();
      end else if (op < 8) merr |= 4;
      else begin
        mz = rz;
        case (op)
          8: npc = na;
          9: if (mc != 0) npc = na;
          10: if (mc == 0) npc = na;
          11: begin
            if (stk.size() == STK_DEPTH) merr |= 1;
            else stk.push_back(npc);
            npc = na;
          end
          12, 13: if (rz == 0) npc = na;
          default: if (rz != 0) npc = na;
        endcase
      end
      mpc = npc;
    end
    @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    int i;
    int op;
    void'($urandom(51));
    repeat (12) @(posedge pclk);
    chk("pc_rst", 0, pc);
    chk("flags_rst", 0, {carry, zero});
    presetn <= 1'b1;
    @(posedge pclk);
    step(11, 0, 'h55, 1, 1, 1);
    apb(1'b1, ADDR_CTRL, 32'h0123_0001);
    mrun = 1;
    apb(1'b1, ADDR_CTRL, 32'h0123_0003);
    mpc = 'h123;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0123_0001, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", 1, se);
    chk("unmapped_data", 0, rd);
    for (i = 0; i < 5; i++) step(11, 0, 'h40 + i, 0, 0, 1);
    status;
    for (i = 0; i < 6; i++) step(i % 6, 1, 0, 1, 0, 1);
    status;
    apb(1'b0, ADDR_ERR, 32'h0);
    chk("err", merr, rd);
    apb(1'b1, ADDR_ERR, 32'h0000_0007);
    merr = 0;
    for (i = 0; i < 400; i++) begin
      op = $urandom_range(15);
      step(op, (op < 6 && $urandom_range(3) == 0), $urandom_range(1023),
           $urandom_range(1), $urandom_range(1), $urandom_range(3) != 0);
      if (i % 50 == 49) status;
    end
    step(0, 0, 0, 0, 0, 0);
    apb(1'b0, ADDR_ERR, 32'h0);
    chk("err_run", merr, rd);
    end_sim;
  end

  initial begin
    #300000;
    err_count++;
    end_sim;
  end
endmodule
